// *** rtl/snap_pkg.sv ***
// Constants for the result snapshot and pin edge refresh block
package snap_pkg;
    // ----------------------------------------------------------------
    // Command codes
    // ----------------------------------------------------------------
    localparam logic [7:0] CMD_SNAP_FULL      = 8'h00; // Full snapshot, clears accumulators
    localparam logic [7:0] CMD_SNAP_FULL_GC   = 8'h1E; // General-call full snapshot
    localparam logic [7:0] CMD_SNAP_KEEP      = 8'h1F; // Keep-accumulator snapshot
    // ----------------------------------------------------------------
    // Pin-edge control register fields
    // ----------------------------------------------------------------
    localparam int         BIT_LEVEL          = 7;     // Live override level
    localparam int         BIT_RISE_SEEN      = 6;     // Sticky rise seen
    localparam int         BIT_FALL_SEEN      = 5;     // Sticky fall seen
    localparam int         BIT_RISE_CLR       = 4;     // Clearing snapshot on rise
    localparam int         BIT_RISE_KEEP      = 3;     // Keep snapshot on rise
    localparam int         BIT_FALL_CLR       = 2;     // Clearing snapshot on fall
    localparam int         BIT_FALL_KEEP      = 1;     // Keep snapshot on fall
    localparam logic [7:0] EDGE_CTRL_RESET    = 8'h00; // Value after reset
    localparam logic [7:0] EDGE_WR_MASK       = 8'h1E; // Host-writable bits
    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int         CLK_HZ             = 50000000; // System clock rate
    localparam int         RESULT_WAIT_US     = 1000;     // Results valid after snapshot
    localparam int         RESULT_WAIT_CYC    = (CLK_HZ / 1000000) * RESULT_WAIT_US;
    // ----------------------------------------------------------------
    // Snapshot kinds
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {SNAP_NONE, SNAP_KEEP, SNAP_CLEAR} snap_kind_t;
endpackage

// *** rtl/result_snapshot.sv ***
// Result snapshot and rate-override pin edge refresh control
//
// Notes on behaviour
// - Keep snapshot is a bare command byte.
// - Keep snapshot leaves accumulators and count alone.
// - Keep snapshot copies accumulators, count, measurements.
// - Results valid within one millisecond.
// - Results hold until the next snapshot.
// - Level bit mirrors the override pin.
// - Rise-seen bit sets on rising edge, sticks.
// - Fall-seen bit sets on falling edge, sticks.
// - Only full snapshots clear edge-seen bits.
// - Rise-clear enable fires clearing snapshot.
// - Fall-clear enable fires clearing snapshot.
// - Keep enables fire keep snapshot per edge.
// - Enable bits change only by host write.
// - Pin snapshots update every result register.
// - Clearing pin snapshot keeps active settings.
// - Pin clearing zeroes accumulators; keep does not.
// - Pin snapshots never activate pending settings.
// - Clearing wins when both enabled together.
// - Edge register writes act immediately, reads live.
// - Lowest edge register bit reads zero.
// - Override pin is captured independently of bus.
// - Full snapshot refreshes and zeroes accumulators.
// - Settings stay pending until host snapshot.
`timescale 1ns/1ps
module result_snapshot
    import snap_pkg::*;
#(
    parameter int MEAS_W   = 16,              // Measurement width
    parameter int ACC_W    = 32,              // Readable accumulator width
    parameter int CNT_W    = 24,              // Accumulator count width
    parameter int CFG_W    = 16,              // Settings register width
    parameter int WAIT_CYC = RESULT_WAIT_CYC  // Cycles until results are guaranteed
)
(
    input  wire logic              CLK_SYS,
    input  wire logic              RESET,
    input  wire logic              CMD_STROBE,
    input  wire logic [7:0]        CMD_CODE,
    input  wire logic              EDGE_WR,
    input  wire logic [7:0]        EDGE_WDATA,
    output logic      [7:0]        EDGE_RDATA,
    input  wire logic              OVERRIDE_PIN,
    input  wire logic [MEAS_W-1:0] LIVE_VBUS,
    input  wire logic [MEAS_W-1:0] LIVE_VSENSE,
    input  wire logic [ACC_W-1:0]  LIVE_ACC,
    input  wire logic [CNT_W-1:0]  LIVE_ACC_CNT,
    input  wire logic [CFG_W-1:0]  PEND_CTRL,
    input  wire logic [CFG_W-1:0]  PEND_POL,
    input  wire logic [CFG_W-1:0]  PEND_ACFG,
    output logic      [MEAS_W-1:0] RES_VBUS,
    output logic      [MEAS_W-1:0] RES_VSENSE,
    output logic      [ACC_W-1:0]  RES_ACC,
    output logic      [CNT_W-1:0]  RES_ACC_CNT,
    output logic      [CFG_W-1:0]  ACTIVE_CTRL,
    output logic      [CFG_W-1:0]  ACTIVE_POL,
    output logic      [CFG_W-1:0]  ACTIVE_ACFG,
    output logic                   ACC_CLEAR,
    output logic                   RESULTS_VALID
);

    // ----------------------------------------------------------------
    // Command decoding
    // ----------------------------------------------------------------

    // Classify a command byte into a snapshot kind
    function automatic snap_kind_t decode_cmd(input logic strobe, input logic [7:0] code);
        snap_kind_t k;
        k = SNAP_NONE;
        if (strobe && (code == CMD_SNAP_FULL || code == CMD_SNAP_FULL_GC))
        begin
            k = SNAP_CLEAR;
        end
        else if (strobe && code == CMD_SNAP_KEEP)
        begin
            k = SNAP_KEEP;
        end
        return k;
    endfunction

    snap_kind_t host_kind;   // Snapshot asked by the host this cycle
    snap_kind_t pin_kind;    // Snapshot asked by a pin edge this cycle
    snap_kind_t snap_kind;   // Snapshot actually performed

    // ----------------------------------------------------------------
    // Override pin synchroniser and edge detection
    // ----------------------------------------------------------------
    logic sync1_q, sync1_d;  // First stage, read only by second
    logic sync2_q, sync2_d;  // Second stage, safe level
    logic prev_q,  prev_d;   // Previous safe level
    logic rise, fall;        // One-cycle edge events

    // Next values of the synchroniser chain
    always_comb
    begin
        sync1_d = OVERRIDE_PIN;
        sync2_d = sync1_q;
        prev_d  = sync2_q;
    end

    // Synchroniser registers
    always_ff @(posedge CLK_SYS)
    begin
        if (RESET)
        begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            prev_q  <= 1'b0;
        end
        else
        begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
            prev_q  <= prev_d;
        end
    end

    assign rise = sync2_q & ~prev_q;
    assign fall = ~sync2_q & prev_q;

    // ----------------------------------------------------------------
    // Pin-edge control register
    // ----------------------------------------------------------------
    logic [7:0] edge_q, edge_d;  // Stored sticky and enable bits

    // Pin snapshot selection, clearing wins over keep
    always_comb
    begin
        pin_kind = SNAP_NONE;
        if ((rise && edge_q[BIT_RISE_CLR]) || (fall && edge_q[BIT_FALL_CLR]))
        begin
            pin_kind = SNAP_CLEAR;
        end
        else if ((rise && edge_q[BIT_RISE_KEEP]) || (fall && edge_q[BIT_FALL_KEEP]))
        begin
            pin_kind = SNAP_KEEP;
        end
    end

    assign host_kind = decode_cmd(CMD_STROBE, CMD_CODE);

    // Next register contents: host write, clear, then edge set
    always_comb
    begin
        edge_d = edge_q;
        if (EDGE_WR)
        begin
            edge_d = (edge_q & ~EDGE_WR_MASK) | (EDGE_WDATA & EDGE_WR_MASK);
        end
        if (host_kind == SNAP_CLEAR)
        begin
            edge_d[BIT_RISE_SEEN] = 1'b0;
            edge_d[BIT_FALL_SEEN] = 1'b0;
        end
        if (rise)
        begin
            edge_d[BIT_RISE_SEEN] = 1'b1;
        end
        if (fall)
        begin
            edge_d[BIT_FALL_SEEN] = 1'b1;
        end
        edge_d[BIT_LEVEL] = 1'b0;  // Level comes from the pin, not stored
        edge_d[0]         = 1'b0;
    end

    // Edge register and its read image
    always_ff @(posedge CLK_SYS)
    begin
        if (RESET)
        begin
            edge_q     <= EDGE_CTRL_RESET;
            EDGE_RDATA <= EDGE_CTRL_RESET;
        end
        else
        begin
            edge_q     <= edge_d;
            EDGE_RDATA <= {sync2_q, edge_d[6:1], 1'b0};
        end
    end

    // ----------------------------------------------------------------
    // Snapshot execution
    // ----------------------------------------------------------------
    logic [MEAS_W-1:0] vbus_q, vbus_d;      // Held bus voltage
    logic [MEAS_W-1:0] vsen_q, vsen_d;      // Held sense voltage
    logic [ACC_W-1:0]  acc_q, acc_d;        // Held accumulator
    logic [CNT_W-1:0]  cnt_q, cnt_d;        // Held accumulator count
    logic [CFG_W-1:0]  actl_q, actl_d;      // Active control copy
    logic [CFG_W-1:0]  apol_q, apol_d;      // Active polarity copy
    logic [CFG_W-1:0]  acfg_q, acfg_d;      // Active accumulator config copy
    logic              clr_q, clr_d;        // Accumulator clear pulse
    logic [31:0]       wait_q, wait_d;      // Cycles left until results guaranteed
    logic              valid_q, valid_d;    // Results guaranteed flag

    // Next values of results, active settings and clear pulse
    always_comb
    begin
        snap_kind = (host_kind == SNAP_CLEAR || pin_kind == SNAP_CLEAR) ? SNAP_CLEAR :
                    (host_kind == SNAP_KEEP  || pin_kind == SNAP_KEEP)  ? SNAP_KEEP  :
                    SNAP_NONE;
        vbus_d  = vbus_q;
        vsen_d  = vsen_q;
        acc_d   = acc_q;
        cnt_d   = cnt_q;
        actl_d  = actl_q;
        apol_d  = apol_q;
        acfg_d  = acfg_q;
        clr_d   = 1'b0;
        wait_d  = (wait_q != 32'h0) ? wait_q - 32'h1 : wait_q;
        valid_d = valid_q | (wait_q == 32'h1);
        if (snap_kind != SNAP_NONE)
        begin
            vbus_d  = LIVE_VBUS;
            vsen_d  = LIVE_VSENSE;
            acc_d   = LIVE_ACC;
            cnt_d   = LIVE_ACC_CNT;
            clr_d   = (snap_kind == SNAP_CLEAR);
            wait_d  = WAIT_CYC[31:0];
            valid_d = 1'b0;
        end
        if (host_kind != SNAP_NONE)
        begin
            actl_d = PEND_CTRL;
            apol_d = PEND_POL;
            acfg_d = PEND_ACFG;
        end
    end

    // Result, settings and timer registers
    always_ff @(posedge CLK_SYS)
    begin
        if (RESET)
        begin
            vbus_q  <= '0;
            vsen_q  <= '0;
            acc_q   <= '0;
            cnt_q   <= '0;
            actl_q  <= '0;
            apol_q  <= '0;
            acfg_q  <= '0;
            clr_q   <= 1'b0;
            wait_q  <= 32'h0;
            valid_q <= 1'b1;
        end
        else
        begin
            vbus_q  <= vbus_d;
            vsen_q  <= vsen_d;
            acc_q   <= acc_d;
            cnt_q   <= cnt_d;
            actl_q  <= actl_d;
            apol_q  <= apol_d;
            acfg_q  <= acfg_d;
            clr_q   <= clr_d;
            wait_q  <= wait_d;
            valid_q <= valid_d;
        end
    end

    // Outputs straight from flip-flops
    assign RES_VBUS      = vbus_q;
    assign RES_VSENSE    = vsen_q;
    assign RES_ACC       = acc_q;
    assign RES_ACC_CNT   = cnt_q;
    assign ACTIVE_CTRL   = actl_q;
    assign ACTIVE_POL    = apol_q;
    assign ACTIVE_ACFG   = acfg_q;
    assign ACC_CLEAR     = clr_q;
    assign RESULTS_VALID = valid_q;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RESET);

    sequence s_keep_cmd;
        host_kind == SNAP_KEEP && pin_kind != SNAP_CLEAR;
    endsequence

    sequence s_pin_clear;
        pin_kind == SNAP_CLEAR && host_kind == SNAP_NONE;
    endsequence

    a_keep_no_clear: assert property (s_keep_cmd |=> !ACC_CLEAR)
        else $error("keep snapshot cleared accumulators");
    a_keep_copies_acc: assert property (s_keep_cmd |=> RES_ACC == $past(LIVE_ACC))
        else $error("keep snapshot did not copy accumulator");
    a_results_in_time: assert property (
        snap_kind != SNAP_NONE |=> RES_VBUS == $past(LIVE_VBUS))
        else $error("results not updated after snapshot");
    a_results_hold: assert property (
        snap_kind == SNAP_NONE |=> $stable(RES_VSENSE) && $stable(RES_ACC_CNT))
        else $error("results changed without snapshot");
    a_level_mirror: assert property (##1 EDGE_RDATA[BIT_LEVEL] == $past(sync2_q))
        else $error("level bit does not follow pin");
    a_rise_sticky: assert property (rise |=> EDGE_RDATA[BIT_RISE_SEEN] && edge_q[6])
        else $error("rise seen bit not set");
    a_fall_sticky: assert property (fall |=> EDGE_RDATA[BIT_FALL_SEEN])
        else $error("fall seen bit not set");
    a_keep_no_unstick: assert property (
        edge_q[BIT_RISE_SEEN] && host_kind != SNAP_CLEAR |=> edge_q[BIT_RISE_SEEN])
        else $error("rise seen bit cleared by wrong event");
    // Pulse is one cycle long unless another clearing snapshot follows at once
    a_pin_clear_fires: assert property (
        s_pin_clear |=> ACC_CLEAR and (snap_kind != SNAP_CLEAR |=> !ACC_CLEAR))
        else $error("pin clearing snapshot missed");
    a_pin_no_activate: assert property (
        host_kind == SNAP_NONE |=> $stable(ACTIVE_CTRL) && $stable(ACTIVE_ACFG))
        else $error("active settings changed without host command");
    a_enable_hold: assert property (!EDGE_WR |=> $stable(edge_q[4:1]))
        else $error("enable bits changed without write");
    a_bit0_zero: assert property (EDGE_RDATA[0] == 1'b0)
        else $error("unimplemented bit reads one");

endmodule

// *** verification/host_model.sv ***
// Host controller, override pin driver and measurement source model for the snapshot block
`timescale 1ns/1ps
module host_model
    import snap_pkg::*;
(
    input  wire logic       clk,
    output logic            cmd_strobe,
    output logic [7:0]      cmd_code,
    output logic            edge_wr,
    output logic [7:0]      edge_wdata,
    output logic            pin,
    output logic [7:0]      live_tag
);
    // ------------------------------------------------------------
    // Idle levels
    // ------------------------------------------------------------
    initial
    begin
        cmd_strobe = 1'b0;
        cmd_code   = 8'h00;
        edge_wr    = 1'b0;
        edge_wdata = 8'h00;
        pin        = 1'b0;
        live_tag   = 8'h00;
    end
    // ------------------------------------------------------------
    // Transfers
    // ------------------------------------------------------------
    // Bare command byte, no data bytes after it
    task automatic send_cmd(input logic [7:0] code);
        @(posedge clk);
        #1;
        cmd_strobe = 1'b1;
        cmd_code   = code;
        @(posedge clk);
        #1;
        cmd_strobe = 1'b0;
        cmd_code   = ~code; // Stale byte inverted once released
    endtask
    // Write of the pin-edge control register
    task automatic write_edge(input logic [7:0] data);
        @(posedge clk);
        #1;
        edge_wr    = 1'b1;
        edge_wdata = data;
        @(posedge clk);
        #1;
        edge_wr    = 1'b0;
        edge_wdata = ~data;
    endtask
    // Pin driven by its own controller, apart from any bus traffic
    task automatic set_pin(input logic level);
        @(posedge clk);
        #1;
        pin = level;
    endtask
    // Tag that marks every live measurement and pending setting
    task automatic set_tag(input logic [7:0] v);
        live_tag = v;
    endtask
endmodule

// *** verification/result_snapshot_tb.sv ***
// Self-checking testbench for the result snapshot block
`timescale 1ns/1ps
module result_snapshot_tb
    import snap_pkg::*;
;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    localparam int WAIT = 20;          // Shortened result window
    logic          CLK_SYS;
    logic          RESET;
    logic          CMD_STROBE;
    logic [7:0]    CMD_CODE;
    logic          EDGE_WR;
    logic [7:0]    EDGE_WDATA;
    logic [7:0]    EDGE_RDATA;
    logic          OVERRIDE_PIN;
    logic [15:0]   LIVE_VBUS, LIVE_VSENSE, RES_VBUS, RES_VSENSE;
    logic [31:0]   LIVE_ACC, RES_ACC;
    logic [23:0]   LIVE_ACC_CNT, RES_ACC_CNT;
    logic [15:0]   PEND_CTRL, PEND_POL, PEND_ACFG;
    logic [15:0]   ACTIVE_CTRL, ACTIVE_POL, ACTIVE_ACFG;
    logic          ACC_CLEAR;
    logic          RESULTS_VALID;
    int            failures = 0;
    int            comparisons = 0;
    int            clear_pulses = 0;  // Accumulator clear pulses seen
    int            exp_clr = 0;       // Clear pulses expected
    int            cycles = 0;
    logic [7:0]    tag;               // Measurement tag from the far side
    // ------------------------------------------------------------
    // Design, far side and clock
    // ------------------------------------------------------------
    result_snapshot #(.WAIT_CYC(WAIT)) uut (.CLK_SYS(CLK_SYS), .RESET(RESET),
        .CMD_STROBE(CMD_STROBE), .CMD_CODE(CMD_CODE), .EDGE_WR(EDGE_WR),
        .EDGE_WDATA(EDGE_WDATA), .EDGE_RDATA(EDGE_RDATA), .OVERRIDE_PIN(OVERRIDE_PIN),
        .LIVE_VBUS(LIVE_VBUS), .LIVE_VSENSE(LIVE_VSENSE), .LIVE_ACC(LIVE_ACC),
        .LIVE_ACC_CNT(LIVE_ACC_CNT), .PEND_CTRL(PEND_CTRL), .PEND_POL(PEND_POL),
        .PEND_ACFG(PEND_ACFG), .RES_VBUS(RES_VBUS), .RES_VSENSE(RES_VSENSE),
        .RES_ACC(RES_ACC), .RES_ACC_CNT(RES_ACC_CNT), .ACTIVE_CTRL(ACTIVE_CTRL),
        .ACTIVE_POL(ACTIVE_POL), .ACTIVE_ACFG(ACTIVE_ACFG), .ACC_CLEAR(ACC_CLEAR),
        .RESULTS_VALID(RESULTS_VALID));
    host_model host (.clk(CLK_SYS), .cmd_strobe(CMD_STROBE), .cmd_code(CMD_CODE),
        .edge_wr(EDGE_WR), .edge_wdata(EDGE_WDATA), .pin(OVERRIDE_PIN), .live_tag(tag));
    // Live values and pending settings all follow the tag
    assign LIVE_VBUS    = {tag, 8'h11};
    assign LIVE_VSENSE  = {tag, 8'h22};
    assign LIVE_ACC     = {tag, 24'h334455};
    assign LIVE_ACC_CNT = {tag, 16'h6677};
    assign PEND_CTRL    = {tag, 8'h01};
    assign PEND_POL     = {tag, 8'h02};
    assign PEND_ACFG    = {tag, 8'h03};
    initial
    begin
        CLK_SYS = 1'b0;
        forever #10 CLK_SYS = ~CLK_SYS;
    end
    // Count clear pulses mid-cycle; cut a hang short
    always @(negedge CLK_SYS)
    begin
        if (ACC_CLEAR === 1'b1)
            clear_pulses++;
        cycles++;
        if (cycles == 1000)
        begin
            failures++;
            stop_test();
        end
    end
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Distinct live and pending values tagged by v
    task automatic set_live(input logic [7:0] v);
        host.set_tag(v);
    endtask
    task automatic chk_res(input logic [7:0] v);
        check("RES_VBUS", {16'h0, v, 8'h11}, {16'h0, RES_VBUS});
        check("RES_VSENSE", {16'h0, v, 8'h22}, {16'h0, RES_VSENSE});
        check("RES_ACC", {v, 24'h334455}, RES_ACC);
        check("RES_ACC_CNT", {8'h0, v, 16'h6677}, {8'h0, RES_ACC_CNT});
    endtask
    task automatic chk_act(input logic [7:0] v);
        check("ACTIVE_CTRL", {16'h0, v, 8'h01}, {16'h0, ACTIVE_CTRL});
        check("ACTIVE_POL", {16'h0, v, 8'h02}, {16'h0, ACTIVE_POL});
        check("ACTIVE_ACFG", {16'h0, v, 8'h03}, {16'h0, ACTIVE_ACFG});
    endtask
    task automatic chk_edge(input logic [7:0] exp);
        check("EDGE_RDATA", {24'h0, exp}, {24'h0, EDGE_RDATA});
        check("ACC_CLEAR pulses", exp_clr, clear_pulses);
    endtask
    task automatic stop_test();
        if (failures == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        logic [7:0] codes [2];
        codes = '{CMD_SNAP_FULL, CMD_SNAP_FULL_GC};
        set_live(8'h00);
        RESET = 1'b1;
        repeat (6) @(posedge CLK_SYS);
        #1;
        RESET = 1'b0;
        chk_edge(8'h00);
        check("RES_VBUS RES_VSENSE", 32'h0, {RES_VBUS, RES_VSENSE});
        check("RES_ACC", 32'h0, RES_ACC);
        check("RES_ACC_CNT", 32'h0, {8'h0, RES_ACC_CNT});
        check("ACTIVE_CTRL ACTIVE_POL", 32'h0, {ACTIVE_CTRL, ACTIVE_POL});
        check("ACTIVE_ACFG", 32'h0, {16'h0, ACTIVE_ACFG});
        check("RESULTS_VALID", 32'h1, RESULTS_VALID);
        // Only enables are stored, bit 0 reads zero
        host.write_edge(8'hFF);
        chk_edge(8'h1E);
        // Keep snapshot copies live values, leaves accumulators
        set_live(8'h01);
        host.send_cmd(CMD_SNAP_KEEP);
        check("RESULTS_VALID", 0, RESULTS_VALID);
        set_live(8'h02);
        @(posedge CLK_SYS);
        #1;
        chk_res(8'h01);
        chk_act(8'h01);
        chk_edge(8'h1E);
        repeat (WAIT + 2) @(posedge CLK_SYS);
        #1;
        check("RESULTS_VALID", 1, RESULTS_VALID);
        chk_res(8'h01);
        // Rise with clear and keep both enabled: one clearing snapshot
        host.set_pin(1'b1);
        repeat (6) @(posedge CLK_SYS);
        #1;
        exp_clr++;
        chk_edge(8'hDE);
        chk_res(8'h02);
        chk_act(8'h01);
        // Keep snapshot leaves seen bits set
        set_live(8'h03);
        host.send_cmd(CMD_SNAP_KEEP);
        @(posedge CLK_SYS);
        #1;
        chk_edge(8'hDE);
        // Fall with keep enabled only
        host.write_edge(8'h02);
        chk_edge(8'hC2);
        set_live(8'h04);
        host.set_pin(1'b0);
        repeat (6) @(posedge CLK_SYS);
        #1;
        chk_edge(8'h62);
        chk_res(8'h04);
        chk_act(8'h03);
        // Edges without enables, then both full snapshot kinds
        host.write_edge(8'h00);
        for (int i = 0; i < 2; i++)
        begin
            set_live(8'h05 + 8'(i));
            host.set_pin(1'b1);
            repeat (4) @(posedge CLK_SYS);
            host.set_pin(1'b0);
            repeat (6) @(posedge CLK_SYS);
            #1;
            chk_edge(8'h60);
            chk_res(8'h04 + 8'(i));
            host.send_cmd(codes[i]);
            @(posedge CLK_SYS);
            #1;
            exp_clr++;
            chk_edge(8'h00);
            chk_res(8'h05 + 8'(i));
            chk_act(8'h05 + 8'(i));
        end
        // Unknown code changes nothing
        set_live(8'h09);
        host.send_cmd(8'h55);
        @(posedge CLK_SYS);
        #1;
        chk_res(8'h06);
        chk_act(8'h06);
        chk_edge(8'h00);
        stop_test();
    end
endmodule
